// ---- hw/probe_pkg.sv ----
// constants for the second touch-probe position-capture unit
// assumes a 100 MHz control clock and word-addressed parameter access
package probe_pkg;
  // parameter addresses
  localparam logic [11:0] ADDR_POS_BUS = 12'h670;
  localparam logic [11:0] ADDR_POS_USER = 12'h672;
  localparam logic [11:0] ADDR_EVENT_COUNT = 12'h674;
  localparam logic [11:0] ADDR_CONFIG = 12'h676;
  localparam logic [11:0] ADDR_STABLE_TIME = 12'h69a;

  // configuration field positions
  localparam int CFG_ARM_BIT = 0;
  localparam int CFG_POL_BIT = 8;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // stable-duration setting
  localparam logic [15:0] STABLE_RESET = 16'h0005;
  localparam logic [15:0] STABLE_MIN = 16'h0002;
  localparam logic [15:0] STABLE_MAX = 16'h0020;

  // position and counter reset values
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // timing: one stable-duration unit is 31.25 us
  localparam int CLK_PERIOD_PS = 10000;
  localparam int UNIT_TIME_PS = 31250000;
  localparam int UNIT_CYCLES = UNIT_TIME_PS / CLK_PERIOD_PS;
  localparam logic [11:0] UNIT_LAST = 12'(UNIT_CYCLES - 1);
endpackage

// ---- hw/probe_unit_tick.sv ----
// divider giving a one-cycle pulse every 31.25 us
// assumes the 100 MHz control clock
`timescale 1ns/1ps
`default_nettype none
module probe_unit_tick (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  logic [11:0] count_reg;
  logic [11:0] count_next;

  always_comb begin
    if (count_reg == probe_pkg::UNIT_LAST) begin
      count_next = '0;
    end else begin
      count_next = count_reg + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign tick = (count_reg == probe_pkg::UNIT_LAST);
endmodule // probe_unit_tick
`default_nettype wire

// ---- hw/probe_level_filter.sv ----
// stable-level filter for the probe input
// assumes rawIn synchronous to clk and tick from probe_unit_tick
`timescale 1ns/1ps
`default_nettype none
module probe_level_filter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic rawIn,
  input wire logic [15:0] stableTime,
  output logic level
);
  logic level_reg;
  logic level_next;
  logic [15:0] held_reg;
  logic [15:0] held_next;

  always_comb begin
    level_next = level_reg;
    held_next = held_reg;
    if (rawIn == level_reg) begin
      held_next = '0;
    end else if (tick) begin
      // accept once new level held across stableTime ticks
      if (held_reg + 16'h0001 >= stableTime) begin
        level_next = rawIn;
        held_next = '0;
      end else begin
        held_next = held_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      level_reg <= 1'b0;
      held_reg <= '0;
    end else begin
      level_reg <= level_next;
      held_reg <= held_next;
    end
  end

  assign level = level_reg;
endmodule // probe_level_filter
`default_nettype wire

// ---- hw/touch_probe_position_capture.sv ----
// top of the second touch-probe capture unit
// assumes probeIn high means contact closed, all inputs synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module touch_probe_position_capture (
  input wire logic clk,
  input wire logic resetn,
  input wire logic probeIn,
  input wire logic [31:0] posBusUnits,
  input wire logic [31:0] posUserUnits,
  input wire logic [11:0] parAddr,
  input wire logic parWrite,
  input wire logic [31:0] parWrData,
  output logic [31:0] parRdData,
  output logic capturePulse
);
  logic tick;
  logic level;
  logic activeNow;
  logic captureHit;

  logic [31:0] posBus_reg;
  logic [31:0] posBus_next;
  logic [31:0] posUser_reg;
  logic [31:0] posUser_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic arm_reg;
  logic arm_next;
  logic pol_reg;
  logic pol_next;
  logic [15:0] stable_reg;
  logic [15:0] stable_next;
  logic activePrev_reg;
  logic activePrev_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic pulse_reg;
  logic pulse_next;

  probe_unit_tick u_tick (
    .clk(clk),
    .resetn(resetn),
    .tick(tick)
  );

  probe_level_filter u_filter (
    .clk(clk),
    .resetn(resetn),
    .tick(tick),
    .rawIn(probeIn),
    .stableTime(stable_reg),
    .level(level)
  );

  // normally closed inverts the contact sense
  assign activeNow = level ^ pol_reg;
  assign captureHit = arm_reg && activeNow && !activePrev_reg;

  always_comb begin
    posBus_next = posBus_reg;
    posUser_next = posUser_reg;
    count_next = count_reg;
    arm_next = arm_reg;
    pol_next = pol_reg;
    stable_next = stable_reg;
    activePrev_next = activeNow;
    pulse_next = captureHit;
    if (captureHit) begin
      posBus_next = posBusUnits;
      posUser_next = posUserUnits;
      count_next = count_reg + probe_pkg::COUNT_STEP;
      arm_next = 1'b0;
    end
    if (parWrite && parAddr == probe_pkg::ADDR_CONFIG) begin
      // only arm and polarity fields are stored
      arm_next = parWrData[probe_pkg::CFG_ARM_BIT];
      pol_next = parWrData[probe_pkg::CFG_POL_BIT];
    end
    if (parWrite && parAddr == probe_pkg::ADDR_STABLE_TIME) begin
      // out-of-range settings are ignored
      if (parWrData[15:0] >= probe_pkg::STABLE_MIN && parWrData[15:0] <= probe_pkg::STABLE_MAX
          && parWrData[31:16] == 16'h0000) begin
        stable_next = parWrData[15:0];
      end
    end
  end

  always_comb begin
    rd_next = '0;
    unique case (parAddr)
      probe_pkg::ADDR_POS_BUS: begin
        rd_next = posBus_reg;
      end
      probe_pkg::ADDR_POS_USER: begin
        rd_next = posUser_reg;
      end
      probe_pkg::ADDR_EVENT_COUNT: begin
        rd_next = {16'h0000, count_reg};
      end
      probe_pkg::ADDR_CONFIG: begin
        rd_next[probe_pkg::CFG_ARM_BIT] = arm_reg;
        rd_next[probe_pkg::CFG_POL_BIT] = pol_reg;
      end
      probe_pkg::ADDR_STABLE_TIME: begin
        rd_next = {16'h0000, stable_reg};
      end
      default: begin
        rd_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      posBus_reg <= probe_pkg::POS_RESET;
      posUser_reg <= probe_pkg::POS_RESET;
      count_reg <= probe_pkg::COUNT_RESET;
      arm_reg <= probe_pkg::CFG_RESET[probe_pkg::CFG_ARM_BIT];
      pol_reg <= probe_pkg::CFG_RESET[probe_pkg::CFG_POL_BIT];
      stable_reg <= probe_pkg::STABLE_RESET;
      activePrev_reg <= 1'b0;
      rd_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      posBus_reg <= posBus_next;
      posUser_reg <= posUser_next;
      count_reg <= count_next;
      arm_reg <= arm_next;
      pol_reg <= pol_next;
      stable_reg <= stable_next;
      activePrev_reg <= activePrev_next;
      rd_reg <= rd_next;
      pulse_reg <= pulse_next;
    end
  end

  assign parRdData = rd_reg;
  assign capturePulse = pulse_reg;
endmodule // touch_probe_position_capture
`default_nettype wire

// ---- dv/probe_switch.sv ----
// touch-probe contact model, high while closed
// assumes closeReq is driven at the clock edge
`timescale 1ns/1ps
`default_nettype none
module probe_switch (
  input wire logic clk,
  input wire logic closeReq,
  output logic probeIn
);
  initial probeIn = 1'b0;
  always @(posedge clk) probeIn <= closeReq;
endmodule // probe_switch
`default_nettype wire

// ---- dv/touch_probe_props.sv ----
// port assertions of the capture unit
// assumes the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module touch_probe_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] parAddr,
  input wire logic [31:0] posUserUnits,
  input wire logic [31:0] parRdData,
  input wire logic capturePulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_clear: assert property ($rose(resetn) |-> !parRdData && !capturePulse)
    else $error("reset");
  a_pulse_single: assert property (capturePulse |=> !capturePulse)
    else $error("pulse");
  a_gap_zero: assert property (parAddr == 12'h671 |=> parRdData == 32'h0)
    else $error("gap");
  a_config_mask: assert property (parAddr == 12'h676 |=> !(parRdData & 32'hfffffefe))
    else $error("config");
  a_count_width: assert property (parAddr == 12'h674 |=> parRdData[31:16] == 16'h0)
    else $error("width");
  a_stable_range: assert property (parAddr == 12'h69a |=> parRdData inside {[2:32]})
    else $error("stable");
  // read data lags the captured register by one cycle, so look one cycle after the pulse
  a_user_capture: assert property (capturePulse && parAddr == 12'h672
    && $past(parAddr) == 12'h672 |=> parRdData == $past(posUserUnits, 2))
    else $error("position");
  a_count_step: assert property (capturePulse && parAddr == 12'h674
    && $past(parAddr) == 12'h674 |=> parRdData == $past(parRdData) + 32'h1)
    else $error("count");
endmodule // touch_probe_props
bind touch_probe_position_capture touch_probe_props i_props (.clk, .resetn, .parAddr,
  .posUserUnits, .parRdData, .capturePulse);
`default_nettype wire

// ---- dv/test_touch_probe_position_capture.sv ----
// bench of the probe capture unit
// assumes the probe_switch model
`timescale 1ns/1ps
`default_nettype none
module test_touch_probe_position_capture;
  logic clk = 1'b0, resetn = 1'b0, closeReq = 1'b0, parWrite = 1'b0, probeIn, capturePulse;
  logic [11:0] parAddr = 12'h0;
  logic [31:0] parWrData = 32'h0, parRdData;
  logic [31:0] posBusUnits = 32'h80000001, posUserUnits = 32'h7fffffff;
  int errors = 0, samples_checked = 0;
  always #5 clk = ~clk;
  probe_switch i_probe_switch (.clk, .closeReq, .probeIn);
  touch_probe_position_capture i_touch_probe_position_capture (.clk, .resetn, .probeIn,
    .posBusUnits, .posUserUnits, .parAddr, .parWrite, .parWrData, .parRdData, .capturePulse);
  task complete_run;
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t %h %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {parAddr, parWrData, parWrite} <= {a, d, 1'b1};
    @(posedge clk);
    parWrite <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    parAddr <= a;
    repeat (2) @(posedge clk);
    #1 chk(parRdData, exp);
  endtask
  // moves the contact, then counts cycles to the capture pulse
  task cap(input logic [11:0] a, input logic v, input logic want);
    int n;
    n = 0;
    @(posedge clk);
    {parAddr, closeReq} <= {a, v};
    while (n < 12000 && capturePulse !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(n > 3124 && n < 12000), 32'(want));
    if (want && n == 12000) complete_run();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(12'h69a, 32'h5);
    rd(12'h674, 32'h0);
    rd(12'h676, 32'h0);
    wr(12'h69a, 32'h21);
    rd(12'h69a, 32'h5);
    wr(12'h69a, 32'h2);
    rd(12'h69a, 32'h2);
    cap(12'h674, 1'b1, 1'b0);
    cap(12'h674, 1'b0, 1'b0);
    wr(12'h676, 32'h1);
    cap(12'h674, 1'b1, 1'b1);
    rd(12'h674, 32'h1);
    rd(12'h676, 32'h0);
    rd(12'h670, 32'h80000001);
    rd(12'h672, 32'h7fffffff);
    @(posedge clk);
    posUserUnits <= 32'h80000001;
    wr(12'h676, 32'h101);
    rd(12'h676, 32'h101);
    cap(12'h672, 1'b0, 1'b1);
    rd(12'h672, 32'h80000001);
    wr(12'h674, 32'h55);
    rd(12'h674, 32'h2);
    complete_run();
  end
endmodule // test_touch_probe_position_capture
`default_nettype wire
